// *** pkg/reset_combiner_pkg.sv ***
// Package with register layout, reset values, bus response codes and source types for the reset source combiner.
// Notes on behaviour
// - Merge all reset sources into one output.
// - Any active source asserts master reset.
// - Defined registers reset; others keep contents.
// - Each reset type sets its own flag.
// - Power-on clears all flags except power-on and brown-out.
// - Software writes flags freely, never resets.
// - Trap conflict sets bit 15.
// - Bit 8 keeps regulator active in sleep.
// - Master clear pin reset sets bit 7.
// - Software reset instruction sets bit 6.
// - Watchdog timeout sets bit 4.
// - Sleep entry sets bit 3.
// - Idle entry sets bit 2.
// - Power-on reset sets bit 0.
// - Power-save, power-on, brown-out clear watchdog flag.
`default_nettype none
package reset_combiner_pkg;
    localparam logic [11:0] cause_offset       = 12'h000;
    localparam logic [11:0] source_offset      = 12'h004;
    localparam int          cause_width        = 16;
    localparam int          trap_bit           = 15;
    localparam int          bad_opcode_bit     = 14;
    localparam int          regulator_bit      = 8;
    localparam int          pin_clear_bit      = 7;
    localparam int          soft_reset_bit     = 6;
    localparam int          watchdog_en_bit    = 5;
    localparam int          watchdog_to_bit    = 4;
    localparam int          sleep_bit          = 3;
    localparam int          idle_bit           = 2;
    localparam int          brownout_bit       = 1;
    localparam int          power_on_bit       = 0;
    localparam logic [15:0] cause_reset_value  = 16'h0003;
    localparam logic [15:0] cause_write_mask   = 16'hC1FF;
    localparam logic [1:0]  resp_okay          = 2'h0;
    localparam logic [1:0]  resp_decerr        = 2'h3;

    typedef struct packed {
        logic power_on;
        logic brownout;
        logic pin_clear;
        logic soft_reset;
        logic watchdog;
        logic trap_conflict;
        logic bad_opcode;
    } reset_sources_type;

    typedef struct packed {
        logic enter_sleep;
        logic enter_idle;
    } power_save_type;
endpackage
`default_nettype wire

// *** design/axil_reg_port.sv ***
// AXI4-Lite slave handshake for a small register file with registered read data.
`default_nettype none
module axil_reg_port #(
    parameter int addr_width = 12
) (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [addr_width-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [addr_width-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    output logic                       wr_en,
    output logic [addr_width-1:0]      wr_addr,
    output logic [31:0]                wr_data,
    output logic [3:0]                 wr_strb,
    output logic [addr_width-1:0]      rd_addr,
    output logic                       rd_en,
    input  wire logic [31:0]           rd_data,
    input  wire logic                  rd_hit,
    input  wire logic                  wr_hit
);
    import reset_combiner_pkg::*;

    logic                  aw_held_reg;
    logic                  w_held_reg;
    logic [addr_width-1:0] aw_addr_reg;
    logic [31:0]           w_data_reg;
    logic [3:0]            w_strb_reg;

    // Refuse address widths too narrow to tell word offsets apart.
    if (addr_width < 4) begin : g_addr_check
        $error("addr_width too small");
    end

    assign awready = !aw_held_reg && !bvalid;
    assign wready  = !w_held_reg && !bvalid;
    assign wr_en   = aw_held_reg && w_held_reg && !bvalid;
    assign wr_addr = aw_addr_reg;
    assign wr_data = w_data_reg;
    assign wr_strb = w_strb_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= 32'h00000000;
            w_strb_reg  <= 4'h0;
            bvalid      <= 1'b0;
            bresp       <= resp_okay;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= wdata;
                w_strb_reg <= wstrb;
            end
            if (wr_en) begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid      <= 1'b1;
                bresp       <= wr_hit ? resp_okay : resp_decerr;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    assign arready = !rvalid;
    assign rd_addr = araddr;
    assign rd_en   = arvalid && arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h00000000;
            rresp  <= resp_okay;
        end else if (rd_en) begin
            rvalid <= 1'b1;
            rdata  <= rd_hit ? rd_data : 32'h00000000;
            rresp  <= rd_hit ? resp_okay : resp_decerr;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** design/reset_source_combiner.sv ***
// Reset source combiner: master reset output and reset cause register over AXI4-Lite.
//
// Chosen here: register access over AXI4-Lite and the address map.
`default_nettype none
module reset_source_combiner (
    input  wire logic                                  aclk,
    input  wire logic                                  aresetn,
    input  wire reset_combiner_pkg::reset_sources_type reset_sources,
    input  wire reset_combiner_pkg::power_save_type    power_save_instruction,
    output logic                                       master_reset_out,
    output logic                                       regulator_sleep_keep,
    output logic                                       watchdog_soft_enable,
    input  wire logic [11:0]                           awaddr,
    input  wire logic                                  awvalid,
    output logic                                       awready,
    input  wire logic [31:0]                           wdata,
    input  wire logic [3:0]                            wstrb,
    input  wire logic                                  wvalid,
    output logic                                       wready,
    output logic [1:0]                                 bresp,
    output logic                                       bvalid,
    input  wire logic                                  bready,
    input  wire logic [11:0]                           araddr,
    input  wire logic                                  arvalid,
    output logic                                       arready,
    output logic [31:0]                                rdata,
    output logic [1:0]                                 rresp,
    output logic                                       rvalid,
    input  wire logic                                  rready
);
    import reset_combiner_pkg::*;

    logic [15:0] cause_reg;
    logic [15:0] cause_next;
    logic        wr_en;
    logic [11:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic [11:0] rd_addr;
    logic        rd_en;
    logic [31:0] rd_data;
    logic        rd_hit;
    logic        wr_hit;

    function automatic logic is_mapped(input logic [11:0] addr);
        is_mapped = (addr[11:2] == cause_offset[11:2]) || (addr[11:2] == source_offset[11:2]);
    endfunction

    // Any active source asserts the combined reset; it is a level from the sources.
    assign master_reset_out = |reset_sources;

    assign regulator_sleep_keep = cause_reg[regulator_bit];
    assign watchdog_soft_enable = cause_reg[watchdog_en_bit];

    always_comb begin
        cause_next = cause_reg;
        // Software write: status only, it never feeds the combined reset.
        if (wr_en && wr_addr[11:2] == cause_offset[11:2]) begin
            if (wr_strb[0]) begin
                cause_next[7:0] = wr_data[7:0];
            end
            if (wr_strb[1]) begin
                cause_next[15:8] = wr_data[15:8];
            end
            cause_next = cause_next & cause_write_mask;
        end
        // Clearing events apply next, so hardware sets below win over them.
        if (power_save_instruction.enter_sleep || power_save_instruction.enter_idle) begin
            cause_next[watchdog_to_bit] = 1'b0;
        end
        if (reset_sources.brownout) begin
            cause_next[trap_bit]        = 1'b0;
            cause_next[bad_opcode_bit]  = 1'b0;
            cause_next[soft_reset_bit]  = 1'b0;
            cause_next[watchdog_to_bit] = 1'b0;
            cause_next[sleep_bit]       = 1'b0;
            cause_next[idle_bit]        = 1'b0;
        end
        if (reset_sources.power_on) begin
            // Power-on clears every flag except its own and the brown-out flag, and restores defaults.
            cause_next = cause_reset_value;
        end
        // Each reset type sets its own flag.
        if (reset_sources.trap_conflict) begin
            cause_next[trap_bit] = 1'b1;
        end
        if (reset_sources.bad_opcode) begin
            cause_next[bad_opcode_bit] = 1'b1;
        end
        if (reset_sources.pin_clear) begin
            cause_next[pin_clear_bit] = 1'b1;
        end
        if (reset_sources.soft_reset) begin
            cause_next[soft_reset_bit] = 1'b1;
        end
        if (reset_sources.watchdog) begin
            cause_next[watchdog_to_bit] = 1'b1;
        end
        if (power_save_instruction.enter_sleep) begin
            cause_next[sleep_bit] = 1'b1;
        end
        if (power_save_instruction.enter_idle) begin
            cause_next[idle_bit] = 1'b1;
        end
        if (reset_sources.brownout || reset_sources.power_on) begin
            cause_next[brownout_bit] = 1'b1;
        end
        if (reset_sources.power_on) begin
            cause_next[power_on_bit] = 1'b1;
        end
    end

    // The bus reset stands in for a power-on: it loads the power-on value.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause_reg <= cause_reset_value;
        end else begin
            cause_reg <= cause_next;
        end
    end

    always_comb begin
        rd_data = 32'h00000000;
        if (rd_addr[11:2] == cause_offset[11:2]) begin
            rd_data[15:0] = cause_reg;
        end else if (rd_addr[11:2] == source_offset[11:2]) begin
            rd_data[6:0] = reset_sources;
        end
    end

    assign rd_hit = is_mapped(rd_addr);
    assign wr_hit = is_mapped(wr_addr);

    axil_reg_port #(
        .addr_width (12)
    ) bus_port (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .rd_addr (rd_addr),
        .rd_en   (rd_en),
        .rd_data (rd_data),
        .rd_hit  (rd_hit),
        .wr_hit  (wr_hit)
    );
endmodule
`default_nettype wire

// *** sim/reset_combiner_monitor.sv ***
// Port checker for the reset source combiner and its bind.
`default_nettype none
module reset_combiner_monitor (
    input wire logic                                  aclk,
    input wire logic                                  aresetn,
    input wire reset_combiner_pkg::reset_sources_type reset_sources,
    input wire logic                                  master_reset_out,
    input wire logic                                  regulator_sleep_keep,
    input wire logic                                  awvalid,
    input wire logic                                  awready,
    input wire logic                                  wvalid,
    input wire logic                                  wready,
    input wire logic                                  bvalid,
    input wire logic                                  bready,
    input wire logic                                  arvalid,
    input wire logic                                  arready,
    input wire logic                                  rvalid,
    input wire logic                                  rready,
    input wire logic [31:0]                           rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_reset_merge: assert property (master_reset_out == (|reset_sources))
        else $error("master reset differs from the source or");
    a_power_on_load: assert property (reset_sources.power_on |=> !regulator_sleep_keep)
        else $error("power on did not reload the cause register");
    a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
        else $error("write response late");
    a_read_answer: assert property (arvalid && arready |-> ##[1:2] rvalid)
        else $error("read data late");
    a_bvalid_hold: assert property (bvalid && !bready |=> bvalid)
        else $error("write response dropped");
    a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped or changed");
    a_read_blocked: assert property (rvalid |-> !arready)
        else $error("read address taken while data pending");
    a_write_blocked: assert property (bvalid |-> !(awready || wready))
        else $error("write taken while response pending");
    c_write: cover property (bvalid && bready);
    c_read: cover property (rvalid && rready);
    c_reset: cover property (master_reset_out);
endmodule
bind reset_source_combiner reset_combiner_monitor u_mon (
    .aclk(aclk), .aresetn(aresetn), .reset_sources(reset_sources),
    .master_reset_out(master_reset_out), .regulator_sleep_keep(regulator_sleep_keep),
    .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
    .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready), .rdata(rdata));
`default_nettype wire

// *** sim/reset_source_model.sv ***
// Model of the reset and power-save event sources that feed the combiner.
`default_nettype none
module reset_source_model (
    input  wire logic                                  aclk,
    input  wire logic                                  go,
    input  wire logic [8:0]                            pat,
    output var  reset_combiner_pkg::reset_sources_type src,
    output var  reset_combiner_pkg::power_save_type    ps
);
    timeunit 1ns;
    timeprecision 1ps;
    import reset_combiner_pkg::*;
    // Sources follow pat one cycle after go and stay high for as many cycles as go is held.
    initial begin
        src = '0;
        ps = '0;
    end
    always @(posedge aclk) begin
        src <= go ? pat[6:0] : 7'h00;
        ps  <= go ? pat[8:7] : 2'h0;
    end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the reset source combiner.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import reset_combiner_pkg::*;
    logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, go;
    logic              awready, wready, bvalid, arready, rvalid, master_reset_out;
    logic              regulator_sleep_keep, watchdog_soft_enable;
    logic [11:0]       awaddr, araddr;
    logic [31:0]       wdata, rdata, seen;
    logic [1:0]        bresp, rresp, resp;
    logic [8:0]        pat;
    logic [3:0]        wstrb;
    int                bad_count, compares, cycles;
    reset_sources_type reset_sources;
    power_save_type    power_save_instruction;
    localparam logic [15:0] pre_tab [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
        16'hC1FF, 16'hC1FF, 16'h0010, 16'h0010};
    localparam logic [8:0] pat_tab [9] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020,
        9'h040, 9'h100, 9'h080};
    localparam logic [15:0] exp_tab [9] = '{16'h4000, 16'h8000, 16'h0010, 16'h0040, 16'h0080,
        16'h01A3, 16'h0003, 16'h0008, 16'h0004};
    reset_source_model u_model (.aclk(aclk), .go(go), .pat(pat), .src(reset_sources),
        .ps(power_save_instruction));
    reset_source_combiner u_dut (.aclk(aclk), .aresetn(aresetn), .reset_sources(reset_sources),
        .power_save_instruction(power_save_instruction), .master_reset_out(master_reset_out),
        .regulator_sleep_keep(regulator_sleep_keep), .watchdog_soft_enable(watchdog_soft_enable),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // One write or one read; handshakes are judged on values settled before the edge.
    task automatic bus(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        logic a_hs, w_hs, r_hs, fin;
        @(posedge aclk);
        awaddr  <= addr;
        araddr  <= addr;
        wdata   <= data;
        awvalid <= wr;
        wvalid  <= wr;
        bready  <= wr;
        arvalid <= !wr;
        rready  <= !wr;
        fin = 1'b0;
        while (!fin) begin
            @(negedge aclk);
            a_hs = awvalid && awready;
            w_hs = wvalid && wready;
            r_hs = arvalid && arready;
            fin = (bvalid && bready) || (rvalid && rready);
            resp = wr ? bresp : rresp;
            seen = rdata;
            @(posedge aclk);
            if (a_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (r_hs) arvalid <= 1'b0;
        end
        bready <= 1'b0;
        rready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input logic [1:0] rsp);
        bus(1'b0, addr, 32'h0000_0000);
        check("read data", seen, exp);
        check("read response", {30'h0, resp}, {30'h0, rsp});
    endtask
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = 7'h00;
        {awaddr, araddr, wdata, pat} = '0;
        wstrb = 4'hF;
        {bad_count, compares, cycles} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(cause_offset, 32'h0000_0003, resp_okay);
        rd(source_offset, 32'h0000_0000, resp_okay);
        rd(12'h008, 32'h0000_0000, resp_decerr);
        bus(1'b1, cause_offset, 32'hFFFF_FFFF);
        check("write response", {30'h0, resp}, {30'h0, resp_okay});
        @(negedge aclk);
        check("master reset", {31'h0, master_reset_out}, 32'h0);
        check("regulator keep", {31'h0, regulator_sleep_keep}, 32'h1);
        check("watchdog enable", {31'h0, watchdog_soft_enable}, 32'h1);
        rd(cause_offset, 32'h0000_C1FF, resp_okay);
        bus(1'b1, 12'h008, 32'h0000_0000);
        check("write response", {30'h0, resp}, {30'h0, resp_decerr});
        $display("register test done");
        for (int i = 0; i < 9; i++) begin
            bus(1'b1, cause_offset, {16'h0000, pre_tab[i]});
            @(posedge aclk);
            go  <= 1'b1;
            pat <= pat_tab[i];
            @(posedge aclk);
            go <= 1'b0;
            @(negedge aclk);
            check("master reset", {31'h0, master_reset_out}, {31'h0, |pat[6:0]});
            rd(cause_offset, {16'h0000, exp_tab[i]}, resp_okay);
        end
        $display("source test done");
        // Only byte lane 0 is enabled, so the upper half must keep its zeros.
        wstrb <= 4'h1;
        bus(1'b1, cause_offset, 32'h0000_FFFF);
        wstrb <= 4'hF;
        rd(cause_offset, 32'h0000_00FF, resp_okay);
        check("regulator keep", {31'h0, regulator_sleep_keep}, 32'h0);
        // The source pulse lands on the edge that applies the write of zero.
        pat <= 9'h01C;
        fork
            bus(1'b1, cause_offset, 32'h0000_0000);
            begin
                @(posedge aclk);
                go <= 1'b1;
                @(posedge aclk);
                go <= 1'b0;
            end
        join
        rd(cause_offset, 32'h0000_00D0, resp_okay);
        go <= 1'b1;
        rd(source_offset, 32'h0000_001C, resp_okay);
        check("master reset", {31'h0, master_reset_out}, 32'h1);
        go <= 1'b0;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(cause_offset, 32'h0000_0003, resp_okay);
        $display("mixed test done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
